// >>> etp_regs.v
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "etp_regs_map.vh"

// =====================================================================
// threshold preset register bank behind a classic wishbone slave
module etp_regs #(
  parameter ADR_W = 10
) (
  input wire mclk,
  input wire srst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [ADR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  output wire [7:0] first_preset_level_nine,
  output wire [7:0] first_preset_level_ten,
  output wire [7:0] first_preset_level_eleven,
  output wire [7:0] first_preset_level_twelve,
  output wire [3:0] first_preset_level_offset,
  output reg [3:0] offset_twos_q,
  output wire [3:0] second_preset_time_one,
  output wire [3:0] second_preset_time_two,
  output wire [13:0] time_one_us,
  output wire [13:0] time_two_us
);
  wire req_new;
  wire wr_lane0;
  wire [7:0] reg_idx;
  reg [7:0] lvl9_q;
  reg [7:0] lvl10_q;
  reg [7:0] lvl11_q;
  reg [7:0] lvl12_q;
  reg [3:0] offset_q;
  reg [7:0] time_q;
  reg [7:0] rdata_q;
  reg [7:0] rdata_d;
  reg [3:0] offset_twos_d;
  // one write strobe per register
  wire wr_lvl9;
  wire wr_lvl10;
  wire wr_lvl11;
  wire wr_lvl12;
  wire wr_offset;
  wire wr_time;

  // =====================================================================
  // write strobe decode, one compare per register
  // lane 0 must be on and the index must match exactly
  function etp_wr_hit;
    input wr_ok;
    input [7:0] idx;
    input [7:0] target;
    begin
      etp_wr_hit = wr_ok & (idx == target);
    end
  endfunction

  // =====================================================================
  // signed magnitude in, two's complement out
  // minus zero folds to zero, so minus seven is the lowest value reached
  function [3:0] etp_sm_to_twos;
    input [3:0] sm;
    begin
      if (sm[`ETP_OFFSET_SIGN]) begin
        etp_sm_to_twos = 4'h0 - {1'b0, sm[2:0]};
      end else begin
        etp_sm_to_twos = {1'b0, sm[2:0]};
      end
    end
  endfunction

  // =====================================================================
  // bus front end
  etp_wb_slave #(.ADR_W(ADR_W)) u_slave (
    .mclk(mclk),
    .srst(srst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_ack_o(wb_ack_o),
    .req_new(req_new),
    .wr_lane0(wr_lane0),
    .reg_idx(reg_idx)
  );

  // =====================================================================
  // write strobes; a misaligned or unmapped index matches none of them
  assign wr_lvl9 = etp_wr_hit(wr_lane0, reg_idx, `ETP_IDX_LEVEL_9);
  assign wr_lvl10 = etp_wr_hit(wr_lane0, reg_idx, `ETP_IDX_LEVEL_10);
  assign wr_lvl11 = etp_wr_hit(wr_lane0, reg_idx, `ETP_IDX_LEVEL_11);
  assign wr_lvl12 = etp_wr_hit(wr_lane0, reg_idx, `ETP_IDX_LEVEL_12);
  assign wr_offset = etp_wr_hit(wr_lane0, reg_idx, `ETP_IDX_OFFSET);
  assign wr_time = etp_wr_hit(wr_lane0, reg_idx, `ETP_IDX_TIME_1_2);

  // =====================================================================
  // level nine; deliberately no reset so contents start unknown
  always @(posedge mclk) begin
    if (wr_lvl9) begin
      lvl9_q <= wb_dat_i[7:0];
    end
  end

  // =====================================================================
  // level ten; no reset, held until rewritten
  always @(posedge mclk) begin
    if (wr_lvl10) begin
      lvl10_q <= wb_dat_i[7:0];
    end
  end

  // =====================================================================
  // level eleven; no reset, held until rewritten
  always @(posedge mclk) begin
    if (wr_lvl11) begin
      lvl11_q <= wb_dat_i[7:0];
    end
  end

  // =====================================================================
  // level twelve; no reset, held until rewritten
  always @(posedge mclk) begin
    if (wr_lvl12) begin
      lvl12_q <= wb_dat_i[7:0];
    end
  end

  // =====================================================================
  // level offset; upper nibble is not stored, so writes there vanish
  always @(posedge mclk) begin
    if (wr_offset) begin
      offset_q <= wb_dat_i[`ETP_OFFSET_MSB:0];
    end
  end

  // =====================================================================
  // both time codes of the second preset live in one byte
  always @(posedge mclk) begin
    if (wr_time) begin
      time_q <= wb_dat_i[7:0];
    end
  end

  // =====================================================================
  // read mux; unmapped indices read zero
  always @* begin
    case (reg_idx)
      `ETP_IDX_LEVEL_9: rdata_d = lvl9_q;
      `ETP_IDX_LEVEL_10: rdata_d = lvl10_q;
      `ETP_IDX_LEVEL_11: rdata_d = lvl11_q;
      `ETP_IDX_LEVEL_12: rdata_d = lvl12_q;
      `ETP_IDX_OFFSET: rdata_d = {`ETP_RSVD_READ, offset_q};
      `ETP_IDX_TIME_1_2: rdata_d = time_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // read data captured with the request, valid while ack is high
  always @(posedge mclk) begin
    if (srst) begin
      rdata_q <= 8'h00;
    end else if (req_new) begin
      rdata_q <= rdata_d;
    end
  end
  assign wb_dat_o = {24'h000000, rdata_q};

  // =====================================================================
  // offset recoded for the comparator; 1000b is minus zero
  always @* begin
    offset_twos_d = etp_sm_to_twos(offset_q);
  end

  always @(posedge mclk) begin
    offset_twos_q <= offset_twos_d;
  end

  // =====================================================================
  // level outputs toward the comparator, straight from the flops
  assign first_preset_level_nine = lvl9_q;
  assign first_preset_level_ten = lvl10_q;
  assign first_preset_level_eleven = lvl11_q;
  assign first_preset_level_twelve = lvl12_q;

  // =====================================================================
  // offset leaves in its stored signed magnitude form
  assign first_preset_level_offset = offset_q;

  // =====================================================================
  // time codes split out of their shared byte
  assign second_preset_time_one = time_q[`ETP_TIME_ONE_MSB:`ETP_TIME_ONE_LSB];
  assign second_preset_time_two = time_q[`ETP_TIME_TWO_MSB:`ETP_TIME_TWO_LSB];

  // =====================================================================
  // both time fields share one decode table
  etp_time_dec u_dec_one (
    .mclk(mclk),
    .time_code(second_preset_time_one),
    .time_us(time_one_us)
  );

  etp_time_dec u_dec_two (
    .mclk(mclk),
    .time_code(second_preset_time_two),
    .time_us(time_two_us)
  );
endmodule

// >>> etp_regs_asserts.sv
`timescale 1ns/1ps
// =====================================================================
// bus and field checks for the threshold preset bank
module etp_regs_asserts #(
  parameter ADR_W = 10
) (
  input wire mclk,
  input wire srst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [ADR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [7:0] first_preset_level_nine,
  input wire [7:0] first_preset_level_twelve,
  input wire [3:0] first_preset_level_offset,
  input wire [3:0] second_preset_time_one,
  input wire [3:0] second_preset_time_two,
  input wire [13:0] time_one_us
);
  // write as the slave takes it; ack low marks a fresh request
  wire wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  wire rd = wb_ack_o & ~wb_we_i;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  a_ack_follows: assert property (wb_cyc_i & wb_stb_i & ~wb_ack_o |=> wb_ack_o)
    else $error("request not acked");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_nine_store: assert property (wr && wb_adr_i == 10'h1A8
    |=> first_preset_level_nine == $past(wb_dat_i[7:0])) else $error("level nine");
  a_twelve_store: assert property (wr && wb_adr_i == 10'h1B4
    |=> first_preset_level_twelve == $past(wb_dat_i[7:0])) else $error("level twelve");
  a_offset_store: assert property (wr && wb_adr_i == 10'h1B8
    |=> first_preset_level_offset == $past(wb_dat_i[3:0])) else $error("offset");
  a_time_store: assert property (wr && wb_adr_i == 10'h1BC
    |=> {second_preset_time_one, second_preset_time_two} == $past(wb_dat_i[7:0]))
    else $error("time codes");
  a_rsvd_read: assert property (rd && wb_adr_i == 10'h1B8 |-> wb_dat_o[7:4] == 4'h0)
    else $error("reserved bits");
  a_nine_read: assert property (rd && wb_adr_i == 10'h1A8
    |-> wb_dat_o == {24'h0, first_preset_level_nine}) else $error("read nine");
  a_decode_top: assert property (second_preset_time_one == 4'hF |=> time_one_us == 14'h1F40)
    else $error("decode top");
  c_write: cover property (wr);
  c_read: cover property (rd);
  c_code_zero: cover property (second_preset_time_one == 4'h0);
endmodule

bind etp_regs etp_regs_asserts #(.ADR_W(ADR_W)) u_etp_regs_asserts (.mclk, .srst, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .first_preset_level_nine, .first_preset_level_twelve, .first_preset_level_offset,
  .second_preset_time_one, .second_preset_time_two, .time_one_us);

// >>> etp_regs_map.vh
// Behaviour
// - byte index 6Ah holds the first preset's ninth threshold level, read/write, bits 7 to 0.
// - byte index 6Bh holds the first preset's tenth threshold level, read/write, bits 7 to 0.
// - byte index 6Ch holds the first preset's eleventh threshold level, read/write, bits 7 to 0.
// - byte index 6Dh holds the first preset's twelfth threshold level, read/write, bits 7 to 0.
// - index 6Eh bits 3 to 0 hold a read/write level offset in sign-magnitude form, top bit the sign.
// - index 6Eh bits 7 to 4 are reserved, read only, and writes to them change nothing.
// - no level, offset or time field is given a value by reset; each starts unknown.
// - index 6Fh bits 7 to 4 hold the second preset's first, absolute, threshold time code.
// - index 6Fh bits 3 to 0 hold the second preset's second, delta, time code with the same table.
// - codes 0 to 3 mean 100 to 400 us, 4 to 8 mean 600 to 1400 us, 9 to 15 the long steps to 8000 us.
`ifndef ETP_REGS_MAP_VH
`define ETP_REGS_MAP_VH

// =====================================================================
// register indices; byte address on the bus is four times the index
`define ETP_IDX_LEVEL_9 8'h6A
`define ETP_IDX_LEVEL_10 8'h6B
`define ETP_IDX_LEVEL_11 8'h6C
`define ETP_IDX_LEVEL_12 8'h6D
`define ETP_IDX_OFFSET 8'h6E
`define ETP_IDX_TIME_1_2 8'h6F

// =====================================================================
// field positions
`define ETP_OFFSET_MSB 3
`define ETP_OFFSET_SIGN 3
`define ETP_RSVD_MSB 7
`define ETP_RSVD_LSB 4
`define ETP_TIME_ONE_MSB 7
`define ETP_TIME_ONE_LSB 4
`define ETP_TIME_TWO_MSB 3
`define ETP_TIME_TWO_LSB 0
`define ETP_RSVD_READ 4'h0

// =====================================================================
// time code table, microseconds
`define ETP_T_US_0 14'h0064 // 100 us
`define ETP_T_US_1 14'h00C8 // 200 us
`define ETP_T_US_2 14'h012C // 300 us
`define ETP_T_US_3 14'h0190 // 400 us
`define ETP_T_US_4 14'h0258 // 600 us
`define ETP_T_US_5 14'h0320 // 800 us
`define ETP_T_US_6 14'h03E8 // 1000 us
`define ETP_T_US_7 14'h04B0 // 1200 us
`define ETP_T_US_8 14'h0578 // 1400 us
`define ETP_T_US_9 14'h07D0 // 2000 us
`define ETP_T_US_10 14'h0960 // 2400 us
`define ETP_T_US_11 14'h0C80 // 3200 us
`define ETP_T_US_12 14'h0FA0 // 4000 us
`define ETP_T_US_13 14'h1450 // 5200 us
`define ETP_T_US_14 14'h1900 // 6400 us
`define ETP_T_US_15 14'h1F40 // 8000 us

`endif

// >>> etp_regs_tb_top.sv
`timescale 1ns/1ps
module etp_regs_tb_top;
  logic mclk, srst, cyc, stb, we;
  logic [9:0] adr;
  logic [3:0] sel, twos;
  logic [31:0] dat, wb_dat_o, seed;
  logic wb_ack_o;
  logic [3:0] t1, t2;
  logic [13:0] us1, us2;
  logic [7:0] v, l9, l10, l11, l12;
  logic [7:0] wv[6];
  logic [3:0] off, ex4;
  logic [31:0] q[$];
  logic [13:0] tus[16] = '{100, 200, 300, 400, 600, 800, 1000, 1200, 1400, 2000, 2400,
    3200, 4000, 5200, 6400, 8000};
  int errors = 0, check_count = 0, i;
  etp_regs u_etp_regs (.mclk(mclk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .first_preset_level_nine(l9), .first_preset_level_ten(l10),
    .first_preset_level_eleven(l11), .first_preset_level_twelve(l12),
    .first_preset_level_offset(off), .offset_twos_q(twos), .second_preset_time_one(t1),
    .second_preset_time_two(t2), .time_one_us(us1), .time_two_us(us2));
  // =====================================================================
  // helpers
  function logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // field port of register k, reserved nibble shown as zero
  function logic [7:0] fld(input int k);
    case (k)
      0: return l9;
      1: return l10;
      2: return l11;
      3: return l12;
      4: return {4'h0, off};
      default: return {t1, t2};
    endcase
  endfunction
  task chk(input logic [31:0] s, input logic [31:0] e, input string nm);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task conclude();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one classic cycle; bounded wait for ack, then one idle cycle
  task wb(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [3:0] s);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; dat <= {24'h0, d};
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk(0, 1, "ack timeout");
      conclude();
    end
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge mclk);
  endtask
  // =====================================================================
  // read watcher: oldest note against the data taken at ack
  always @(posedge mclk) begin
    if (wb_ack_o === 1'b1 && we === 1'b0) begin
      if (q.size() > 0) chk(wb_dat_o, q.pop_front(), "read data");
      else chk(0, 1, "unexpected read");
    end
  end
  initial begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    srst = 1; cyc = 0; stb = 0; we = 0; adr = 0; sel = 0; dat = 0; seed = 5221;
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    // every mapped register: random write, read back; reserved nibble reads 0
    for (i = 0; i < 6; i++) begin
      v = rnd();
      wv[i] = v;
      wb(1, 10'h1A8 + 4 * i, v, 4'hF);
      chk(fld(i), i == 4 ? v & 8'h0F : v, "field port");
      q.push_back(i == 4 ? v & 8'h0F : v);
      wb(0, 10'h1A8 + 4 * i, 8'h00, 4'hF);
    end
    $display("test read back done");
    // lane 0 off, misaligned and unmapped writes change nothing
    wb(1, 10'h1A8, ~wv[0], 4'hE);
    wb(1, 10'h1A9, ~wv[0], 4'hF);
    wb(1, 10'h100, v, 4'hF);
    chk(l9, wv[0], "level nine kept");
    q.push_back(32'h0);
    wb(0, 10'h100, 8'h00, 4'hF);
    q.push_back(wv[0]);
    wb(0, 10'h1A8, 8'h00, 4'hF);
    $display("test ignored writes done");
    // every time code and every offset through the decoders
    for (i = 0; i < 16; i++) begin
      wb(1, 10'h1B8, i, 4'h1);
      wb(1, 10'h1BC, {i[3:0], ~i[3:0]}, 4'h1);
      #1;
      chk(us1, tus[i], "time one");
      chk(us2, tus[15 - i], "time two");
      ex4 = (i >= 8) ? -(i % 8) : i % 8;
      chk(twos, ex4, "twos offset");
    end
    $display("test decode done");
    chk(q.size(), 0, "notes left");
    conclude();
  end
endmodule

// >>> etp_time_dec.v
`timescale 1ns/1ps
`include "etp_regs_map.vh"

// =====================================================================
// registered decode of a 4-bit threshold time code into microseconds
module etp_time_dec (
  input wire mclk,
  input wire [3:0] time_code,
  output reg [13:0] time_us
);
  // table is shared by absolute and delta fields
  function [13:0] code_to_us;
    input [3:0] code;
    begin
      case (code)
        4'h0: code_to_us = `ETP_T_US_0;
        4'h1: code_to_us = `ETP_T_US_1;
        4'h2: code_to_us = `ETP_T_US_2;
        4'h3: code_to_us = `ETP_T_US_3;
        4'h4: code_to_us = `ETP_T_US_4;
        4'h5: code_to_us = `ETP_T_US_5;
        4'h6: code_to_us = `ETP_T_US_6;
        4'h7: code_to_us = `ETP_T_US_7;
        4'h8: code_to_us = `ETP_T_US_8;
        4'h9: code_to_us = `ETP_T_US_9;
        4'hA: code_to_us = `ETP_T_US_10;
        4'hB: code_to_us = `ETP_T_US_11;
        4'hC: code_to_us = `ETP_T_US_12;
        4'hD: code_to_us = `ETP_T_US_13;
        4'hE: code_to_us = `ETP_T_US_14;
        default: code_to_us = `ETP_T_US_15;
      endcase
    end
  endfunction

  // no reset: follows the code, unknown until the code is written
  always @(posedge mclk) begin
    time_us <= code_to_us(time_code);
  end
endmodule

// >>> etp_wb_slave.v
`timescale 1ns/1ps
`include "etp_regs_map.vh"

// =====================================================================
// classic wishbone slave front end: one wait state, answers every address
module etp_wb_slave #(
  parameter ADR_W = 10
) (
  input wire mclk,
  input wire srst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [ADR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  output wire wb_ack_o,
  output wire req_new,
  output wire wr_lane0,
  output wire [7:0] reg_idx
);
  reg ack_q;
  wire [7:0] idx_d;

  // a request is new only while ack is low, so one access makes one strobe
  assign req_new = wb_cyc_i & wb_stb_i & ~ack_q;
  // only byte lane 0 carries register data; other lanes are ignored
  assign wr_lane0 = req_new & wb_we_i & wb_sel_i[0];
  // misaligned byte addresses fold onto no register
  assign idx_d = (wb_adr_i[1:0] == 2'b00) ? wb_adr_i[9:2] : 8'h00;
  assign reg_idx = idx_d;
  assign wb_ack_o = ack_q;

  // ack one cycle after the request, dropped the cycle after
  always @(posedge mclk) begin
    if (srst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req_new;
    end
  end
endmodule
